// file: rtl/uive_consts.svh
`ifndef UIVE_CONSTS_SVH
`define UIVE_CONSTS_SVH

// vector layout
`define UIVE_VEC_W          8
`define UIVE_GRP_MSB        7
`define UIVE_GRP_LSB        4
`define UIVE_IDX_MSB        3
`define UIVE_IDX_LSB        1
`define UIVE_GRP_SLOTS      8
`define UIVE_MAX_GROUPS     16

// reset values
`define UIVE_VEC_NONE       8'h00
`define UIVE_IRQ_N_RST      1'b1

// source codes
`define UIVE_NUM_SRC        22
`define UIVE_VEC_OUT_EP1    8'h12
`define UIVE_VEC_OUT_EP2    8'h14
`define UIVE_VEC_OUT_EP3    8'h16
`define UIVE_VEC_IN_EP1     8'h22
`define UIVE_VEC_IN_EP2     8'h24
`define UIVE_VEC_IN_EP3     8'h26
`define UIVE_VEC_STP_OVWR   8'h30
`define UIVE_VEC_SETUP      8'h32
`define UIVE_VEC_RESUME     8'h36
`define UIVE_VEC_SUSPEND    8'h38
`define UIVE_VEC_BUS_RESET  8'h3a
`define UIVE_VEC_WAKEUP     8'h3c
`define UIVE_VEC_TWI_TXE    8'h40
`define UIVE_VEC_TWI_RXF    8'h42
`define UIVE_VEC_IN_EP0     8'h44
`define UIVE_VEC_OUT_EP0    8'h46
`define UIVE_VEC_UART_STAT  8'h50
`define UIVE_VEC_UART_MODEM 8'h52
`define UIVE_VEC_UART_RXF   8'h60
`define UIVE_VEC_UART_TXE   8'h62
`define UIVE_VEC_DMA_ONE    8'h80
`define UIVE_VEC_DMA_THREE  8'h84

`endif

// file: rtl/uive_pkg.sv
package uive_pkg;

    // one-cycle event pulses from the peripherals
    typedef struct packed {
        logic out_ep1;
        logic out_ep2;
        logic out_ep3;
        logic in_ep1;
        logic in_ep2;
        logic in_ep3;
        logic setup_overwrite_packet;
        logic setup_received;
        logic usb_resume_request;
        logic usb_suspend_request;
        logic usb_bus_reset_request;
        logic usb_wakeup;
        logic twi_transmit_empty_flag;
        logic twi_receive_full_flag;
        logic in_ep0;
        logic out_ep0;
        logic uart_status;
        logic uart_modem;
        logic uart_receive_full_flag;
        logic uart_transmit_empty_flag;
        logic dma_channel_one;
        logic dma_channel_three;
    } uive_src_req_type;

    typedef struct packed {
        logic [7:0] vec;
        logic       irq_n;
    } uive_top_state_type;

endpackage

// file: rtl/uive_grp_fcfs.sv
`timescale 1ns/1ps
`include "uive_consts.svh"

// first-come-first-served arbiter for the sources of one group
module uive_grp_fcfs #(
    parameter int N_SRC = `UIVE_GRP_SLOTS
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic [N_SRC-1:0]   set_src,
    input  wire logic [N_SRC-1:0]   clr_src,
    output logic                    head_valid,
    output logic [2:0]              head_idx
);
    import uive_pkg::*;

    typedef struct packed {
        logic [N_SRC-1:0]            pending;
        logic [N_SRC-1:0][N_SRC-1:0] older;   // older[i][j]: i arrived before j
    } uive_arb_state_type;

    uive_arb_state_type st_reg;
    uive_arb_state_type st_next;
    logic [N_SRC-1:0]   keep;
    logic [N_SRC-1:0]   fresh;

    if (N_SRC < 1 || N_SRC > `UIVE_GRP_SLOTS) begin : g_chk
        $error("uive_grp_fcfs: N_SRC must be 1..8");
    end

    always_comb begin
        keep  = st_reg.pending & ~clr_src;
        fresh = set_src & ~keep;
        st_next = st_reg;
        // a set in the cycle of its clear wins and re-queues the source
        st_next.pending = keep | set_src;
        for (int i = 0; i < N_SRC; i++) begin
            for (int j = 0; j < N_SRC; j++) begin
                if (fresh[i] && fresh[j]) begin
                    st_next.older[i][j] = (i < j);   // same-cycle ties go to the lower slot
                end else if (fresh[i]) begin
                    st_next.older[i][j] = 1'b0;
                end else if (fresh[j]) begin
                    st_next.older[i][j] = 1'b1;
                end else begin
                    st_next.older[i][j] = st_reg.older[i][j];
                end
            end
        end
    end

    // head is the pending source that no other pending source predates
    always_comb begin
        logic blocked;
        blocked    = 1'b0;
        head_valid = 1'b0;
        head_idx   = 3'h0;
        for (int i = 0; i < N_SRC; i++) begin
            blocked = 1'b0;
            for (int j = 0; j < N_SRC; j++) begin
                if (j != i && st_reg.pending[j] && st_reg.older[j][i]) begin
                    blocked = 1'b1;
                end
            end
            if (st_reg.pending[i] && !blocked && !head_valid) begin   // RL10
                head_valid = 1'b1;
                head_idx   = 3'(i);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

endmodule

// file: rtl/uive_encoder.sv
// How it works
// RL1 - the block makes an 8-bit vector code with room for 128 sources, of which only some are used.
// RL2 - priority between groups is fixed in hardware and the highest pending group wins, group 8 (0x80, 0x84) top and group 1 (0x12-0x16) bottom.
// RL3 - every vectored source feeds one combined interrupt line, and the winning vector is shown with it.
// RL4 - input endpoints 1, 2 and 3 are vectors 22, 24 and 26 hex, while 20 and 28 to 2e are reserved.
// RL5 - the setup-overwrite event is vector 30 hex, a received setup packet is 32 hex, and 34 hex is reserved.
// RL6 - usb resume, suspend, bus reset and wakeup are vectors 36, 38, 3a and 3c hex.
// RL7 - 00 means idle and the other sources take 12-16, 40-46, 50-52, 60-62, 80 and 84, the rest unused.
// RL8 - a write of any value to the pending vector retires it and loads the next pending vector, if any.
// RL9 - the group sits in bits 7 to 4, the in-group slot in bits 3 to 1, and bit 0 is always zero.
// RL10 - inside a group sources are served in arrival order, and a higher group always beats a lower one.
// RL11 - firmware sets the combined line as active-low level-sensitive, reads the vector and dispatches on it.
`timescale 1ns/1ps
`include "uive_consts.svh"

module uive_encoder #(
    parameter int NUM_GROUPS = 9
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire uive_pkg::uive_src_req_type src_req,
    input  wire logic                       vec_wr,
    output logic [7:0]                      pending_vector_register,
    output logic                            combined_internal_irq_n
);
    import uive_pkg::*;

    localparam int NSRC  = `UIVE_NUM_SRC;
    localparam int SLOTS = `UIVE_GRP_SLOTS;

    // code table, index k matches bit k of src_bits
    localparam logic [7:0] SRC_CODE [NSRC] = '{
        `UIVE_VEC_DMA_THREE,                                        // RL7
        `UIVE_VEC_DMA_ONE,                                          // RL7
        `UIVE_VEC_UART_TXE,                                         // RL7
        `UIVE_VEC_UART_RXF,                                         // RL7
        `UIVE_VEC_UART_MODEM,                                       // RL7
        `UIVE_VEC_UART_STAT,                                        // RL7
        `UIVE_VEC_OUT_EP0,                                          // RL7
        `UIVE_VEC_IN_EP0,                                           // RL7
        `UIVE_VEC_TWI_RXF,                                          // RL7
        `UIVE_VEC_TWI_TXE,                                          // RL7
        `UIVE_VEC_WAKEUP,                                           // RL6
        `UIVE_VEC_BUS_RESET,                                        // RL6
        `UIVE_VEC_SUSPEND,                                          // RL6
        `UIVE_VEC_RESUME,                                           // RL6
        `UIVE_VEC_SETUP,                                            // RL5
        `UIVE_VEC_STP_OVWR,                                         // RL5
        `UIVE_VEC_IN_EP3,                                           // RL4
        `UIVE_VEC_IN_EP2,                                           // RL4
        `UIVE_VEC_IN_EP1,                                           // RL4
        `UIVE_VEC_OUT_EP3,                                          // RL7
        `UIVE_VEC_OUT_EP2,                                          // RL7
        `UIVE_VEC_OUT_EP1                                           // RL7
    };

    uive_top_state_type             st_reg;
    uive_top_state_type             st_next;
    logic [NSRC-1:0]                src_bits;
    logic [NUM_GROUPS-1:0][SLOTS-1:0] set_grid;
    logic [NUM_GROUPS-1:0][SLOTS-1:0] clr_grid;
    logic [NUM_GROUPS-1:0]          grp_valid;
    logic [NUM_GROUPS-1:0][2:0]     grp_head;
    logic                           win_valid;
    logic [3:0]                     win_grp;
    logic [2:0]                     win_idx;
    logic                           load;

    // every code must land inside an instantiated group
    if (NUM_GROUPS < 9 || NUM_GROUPS > `UIVE_MAX_GROUPS) begin : g_chk
        $error("uive_encoder: NUM_GROUPS must be 9..16");
    end

    // packed struct order puts out_ep1 at the msb, so table index 0 is dma three
    assign src_bits = src_req;

    // spread the flat source pulses onto the group/slot grid
    always_comb begin
        set_grid = '0;
        for (int k = 0; k < NSRC; k++) begin
            set_grid[SRC_CODE[k][`UIVE_GRP_MSB:`UIVE_GRP_LSB]]
                    [SRC_CODE[k][`UIVE_IDX_MSB:`UIVE_IDX_LSB]] = src_bits[k];   // RL9
        end
    end

    // one arrival-order arbiter per group; unused slots never see a set
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        uive_grp_fcfs #(
            .N_SRC      (SLOTS)
        ) u_fcfs (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .clk_en     (clk_en),
            .set_src    (set_grid[g]),
            .clr_src    (clr_grid[g]),
            .head_valid (grp_valid[g]),
            .head_idx   (grp_head[g])
        );
    end

    // highest group with anything pending wins outright
    always_comb begin
        win_valid = 1'b0;
        win_grp   = 4'h0;
        win_idx   = 3'h0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (grp_valid[g]) begin                                  // RL2
                win_valid = 1'b1;
                win_grp   = 4'(g);
                win_idx   = grp_head[g];
            end
        end
    end

    // a vector is latched when the register is idle or the core acknowledges
    assign load = (st_reg.vec == `UIVE_VEC_NONE) || vec_wr;         // RL8

    always_comb begin
        st_next  = st_reg;
        clr_grid = '0;
        if (load) begin
            if (win_valid) begin
                st_next.vec = {win_grp, win_idx, 1'b0};              // RL1 RL9
                // the winner leaves its queue as it is loaded, so an ack does not load it again unless it was set in that same cycle
                clr_grid[win_grp][win_idx] = 1'b1;                   // RL8
            end else begin
                st_next.vec = `UIVE_VEC_NONE;                        // RL7
            end
        end
        // level low while a vector waits; the core must treat it as a level (RL11)
        st_next.irq_n = (st_next.vec == `UIVE_VEC_NONE);             // RL3
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.vec   <= `UIVE_VEC_NONE;
            st_reg.irq_n <= `UIVE_IRQ_N_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign pending_vector_register = st_reg.vec;
    assign combined_internal_irq_n = st_reg.irq_n;

endmodule

// file: tb/uive_encoder_sva.sv
`timescale 1ns/1ps
module uive_encoder_chk (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic                       clk_en,
    input wire uive_pkg::uive_src_req_type src_req,
    input wire logic                       vec_wr,
    input wire logic [7:0]                 pending_vector_register,
    input wire logic                       combined_internal_irq_n
);
    import uive_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_bit_zero: assert property (pending_vector_register[0] == 1'b0)
        else $error("vector bit 0 set");
    a_irq_follows: assert property (combined_internal_irq_n == (pending_vector_register == 8'h00))
        else $error("irq line disagrees with vector");
    a_legal_code: assert property (pending_vector_register inside {8'h00, 8'h12, 8'h14, 8'h16, 8'h22, 8'h24,
        8'h26, 8'h30, 8'h32, 8'h36, 8'h38, 8'h3a, 8'h3c, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60,
        8'h62, 8'h80, 8'h84})
        else $error("reserved vector shown");
    a_hold_vector: assert property (!vec_wr && pending_vector_register != 8'h00 |=> $stable(pending_vector_register))
        else $error("vector changed without ack");
    a_freeze_all: assert property (!clk_en |=> $stable(pending_vector_register))
        else $error("vector moved while clock disabled");
    a_idle_take: assert property ((clk_en && |src_req && pending_vector_register == 8'h00) ##1 (clk_en && !vec_wr)
        |=> pending_vector_register != 8'h00)
        else $error("event not shown two edges after take");
    a_irq_release: assert property ($rose(combined_internal_irq_n) |-> $past(vec_wr) && $past(clk_en))
        else $error("irq released without ack");
    a_reset_first: assert property ($rose(rst_n) |-> pending_vector_register == 8'h00 && combined_internal_irq_n)
        else $error("not idle at first edge after reset");
endmodule

bind uive_encoder uive_encoder_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .src_req(src_req),
    .vec_wr(vec_wr), .pending_vector_register(pending_vector_register),
    .combined_internal_irq_n(combined_internal_irq_n));

// file: tb/uive_core_model.sv
`timescale 1ns/1ps
module uive_core_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       auto_ack,
    input  wire logic [2:0] ack_delay,
    input  wire logic       combined_internal_irq_n,
    input  wire logic [7:0] pending_vector_register,
    output logic            vec_wr,
    output logic [7:0]      seen_vec
);
    logic [2:0] wait_cnt;
    // level sensitive: a line still low after an ack is served again with no new edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_wr <= 1'b0;
            wait_cnt <= 3'h0;
            seen_vec <= 8'h00;
        end else if (vec_wr) begin
            vec_wr <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (auto_ack && !combined_internal_irq_n) begin
            if (wait_cnt >= ack_delay) begin
                seen_vec <= pending_vector_register;
                vec_wr <= 1'b1;
                wait_cnt <= 3'h0;
            end else begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import uive_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             clk_en = 1'b1;
    uive_src_req_type src_req = '0;
    logic             tb_wr = 1'b0;
    logic             auto_ack = 1'b0;
    logic [2:0]       ack_delay = 3'h0;
    logic             core_wr;
    logic             vec_wr;
    logic [7:0]       vec;
    logic             irq_n;
    logic [7:0]       seen_vec;
    int               fail_count = 0;
    int               n_compared = 0;
    logic [7:0]       codes [22] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h36, 8'h38, 8'h3a,
                                     8'h3c, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84};

    assign vec_wr = core_wr | tb_wr;
    always #2 sys_clk = ~sys_clk;

    uive_encoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .src_req(src_req), .vec_wr(vec_wr),
        .pending_vector_register(vec), .combined_internal_irq_n(irq_n));
    uive_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .auto_ack(auto_ack), .ack_delay(ack_delay),
        .combined_internal_irq_n(irq_n), .pending_vector_register(vec), .vec_wr(core_wr), .seen_vec(seen_vec));

    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check(logic [7:0] exp);
        cmp("vector", exp, vec);
        cmp("irq_n", {7'h00, exp == 8'h00}, {7'h00, irq_n});
    endtask
    function automatic uive_src_req_type fld(int k);
        return uive_src_req_type'(22'h1 << (21 - k));
    endfunction
    task automatic fire(uive_src_req_type bits);
        src_req = bits;
        tick(1);
        src_req = '0;
    endtask
    // leaves the ack raised so several can run back to back
    task automatic ack(logic [7:0] exp);
        tb_wr = 1'b1;
        tick(1);
        check(exp);
    endtask
    task automatic each_code;
        for (int k = 0; k < 22; k++) begin
            fire(fld(k));
            tick(1);
            check(codes[k]);
            ack(8'h00);
            tb_wr = 1'b0;
        end
    endtask
    task automatic arrival_order;
        fire(fld(0));
        fire(fld(14));
        fire(fld(21));
        fire(fld(20));
        check(8'h12);
        ack(8'h84);
        ack(8'h80);
        ack(8'h44);
        ack(8'h00);
        tb_wr = 1'b0;
    endtask
    // a pulse still high as its source is loaded queues it again
    task automatic requeue;
        src_req = fld(3);
        tick(2);
        src_req = '0;
        check(8'h22);
        ack(8'h22);
        ack(8'h00);
        tb_wr = 1'b0;
    endtask
    task automatic all_at_once;
        int n;
        n = 0;
        auto_ack = 1'b1;
        fire('1);
        for (int g = 8; g > 0; g--) begin
            for (int k = 0; k < 22; k++) begin
                if (codes[k][7:4] == g) begin
                    tick(1);
                    for (int t = 0; t < 20 && vec_wr !== 1'b1; t++) tick(1);
                    cmp("served", codes[k], seen_vec);
                    ack_delay = n[0] ? 3'h0 : 3'h3;
                    n++;
                end
            end
        end
        auto_ack = 1'b0;
        tick(6);
        check(8'h00);
    endtask
    task automatic freeze_and_reset;
        clk_en = 1'b0;
        fire(fld(5));
        tick(3);
        check(8'h00);
        clk_en = 1'b1;
        fire(fld(8));
        fire(fld(9));
        // frozen: the ack must not be taken and the shown vector must stay
        clk_en = 1'b0;
        tb_wr = 1'b1;
        tick(2);
        check(8'h36);
        clk_en = 1'b1;
        tick(1);
        check(8'h38);
        tb_wr = 1'b0;
        // leave a source queued so the reset has to empty the queues
        fire(fld(10));
        rst_n = 1'b0;
        tick(2);
        check(8'h00);
        rst_n = 1'b1;
        tick(3);
        check(8'h00);
    endtask
    task automatic final_report;
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(16);
        rst_n = 1'b1;
        check(8'h00);
        each_code();
        arrival_order();
        requeue();
        all_at_once();
        freeze_and_reset();
        final_report();
    end
    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end
endmodule
